// ===== design/srf_pkg.sv
package srf_pkg;

  // ==========================================================
  // Byte codes
  // ==========================================================
  localparam logic [7:0] CH_SEMI = 8'h3B;
  localparam logic [7:0] CH_COMMA = 8'h2C;
  localparam logic [7:0] CH_COLON = 8'h3A;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_TAB = 8'h09;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_MINUS = 8'h2D;
  localparam logic [7:0] CH_PLUS = 8'h2B;
  localparam logic [7:0] CH_POINT = 8'h2E;
  localparam logic [7:0] CH_EXP = 8'h45;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_LOW_A = 8'h61;
  localparam logic [7:0] CH_LOW_Z = 8'h7A;
  localparam logic [7:0] CASE_BIT = 8'h20;

  // ==========================================================
  // Sizes and counts
  // ==========================================================
  localparam int CONV_W = 32;
  localparam int EXP_W = 8;
  localparam int NDIGITS = 10;
  localparam int TEXT_BYTES = 8;
  localparam logic [5:0] CONV_STEPS = 6'h20;
  localparam logic [5:0] CONV_LAST = 6'h01;
  localparam logic [3:0] DAB_ADJ_MIN = 4'h5;
  localparam logic [3:0] DAB_ADJ = 4'h3;
  localparam logic [3:0] FRAC_MAX = 4'h9;
  localparam logic [3:0] MIN_ONE = 4'h1;

  // ==========================================================
  // Types
  // ==========================================================
  typedef enum logic [1:0] {
    KIND_CHAR = 2'h0,
    KIND_NR1 = 2'h1,
    KIND_NR2 = 2'h2,
    KIND_NR3 = 2'h3
  } srf_kind_t;

  typedef enum logic [2:0] {
    SEP_NONE = 3'h1,
    SEP_COMMA = 3'h2,
    SEP_SEMI = 3'h4
  } srf_sep_t;

  typedef enum logic [11:0] {
    FS_IDLE = 12'h001,
    FS_TEXT = 12'h002,
    FS_CONV = 12'h004,
    FS_SIGN = 12'h008,
    FS_DIG = 12'h010,
    FS_POINT = 12'h020,
    FS_EXPE = 12'h040,
    FS_EXPCONV = 12'h080,
    FS_EXPSIGN = 12'h100,
    FS_FIN = 12'h200,
    FS_CR = 12'h400,
    FS_LF = 12'h800
  } srf_fmt_state_t;

endpackage

// ===== design/srf_dec_digits.sv
module srf_dec_digits (
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  input wire logic [srf_pkg::CONV_W-1:0] value,
  input wire logic [3:0] min_digits,
  output logic done,
  output logic [4*srf_pkg::NDIGITS-1:0] bcd,
  output logic [3:0] ndig
);
  import srf_pkg::*;

  typedef struct packed {
    logic busy;
    logic done;
    logic [5:0] cnt;
    logic [CONV_W-1:0] sh;
    logic [4*NDIGITS-1:0] bcd;
    logic [3:0] mind;
  } srf_dd_state_t;

  srf_dd_state_t q;
  srf_dd_state_t d;
  logic [4*NDIGITS-1:0] adj;

  // ==========================================================
  // Shift-and-add-three, one bit per clock
  // ==========================================================
  always_comb begin
    d = q;
    adj = q.bcd;
    d.done = 1'b0;
    if (start) begin
      d.busy = 1'b1;
      d.cnt = CONV_STEPS;
      d.sh = value;
      d.bcd = '0;
      d.mind = min_digits;
    end else if (q.busy) begin
      for (int i = 0; i < NDIGITS; i++) begin
        if (adj[i*4 +: 4] >= DAB_ADJ_MIN) begin
          adj[i*4 +: 4] = adj[i*4 +: 4] + DAB_ADJ;
        end
      end
      d.bcd = {adj[4*NDIGITS-2:0], q.sh[CONV_W-1]};
      d.sh = {q.sh[CONV_W-2:0], 1'b0};
      d.cnt = q.cnt - CONV_LAST;
      if (q.cnt == CONV_LAST) begin
        d.busy = 1'b0;
        d.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Significant digits, padded up to the requested minimum
  always_comb begin
    ndig = MIN_ONE;
    for (int i = 0; i < NDIGITS; i++) begin
      if (q.bcd[i*4 +: 4] != 4'h0) begin
        ndig = 4'(i + 1);
      end
    end
    if (q.mind > ndig) begin
      ndig = q.mind;
    end
  end

  assign done = q.done;
  assign bcd = q.bcd;

endmodule

// ===== design/srf_formatter.sv
// How it works
// - Response units carry no header, only the data the query asked for.
// - A response is one or more units in sequence, closed by exactly one terminator.
// - Consecutive units are split by one semicolon with no whitespace around it.
// - Data elements inside a unit are split by one comma with no whitespace around it.
// - Each element is uppercase mnemonic text, a decimal integer, a fixed-point value or an exponent-form value, as the query picks.
// - Exponent form uses an uppercase E and always a sign on the exponent, plus included.
// - Output is uppercase only, with no blanks before headers, around separators or before the terminator.
// - A header followed by data is split from it by exactly one space byte 20h.
// - The terminator is newline plus end by default, and carriage return 0Dh, newline and end when selected.
// - Incoming program text is folded so upper and lower case letters, the exponent letter too, are equal.
// - Incoming whitespace before headers, around separators and before the terminator is tolerated.
// - Each function yields exactly one fixed spelling of its reply.
// - The newline byte is 0Ah.
// - On the instrument bus the end mark is the end line driven low together with the last byte.
module srf_formatter (
  input wire logic clk,
  input wire logic reset,
  // Response elements from the measurement logic
  input wire logic el_valid,
  input wire srf_pkg::srf_kind_t el_kind,
  input wire logic [8*srf_pkg::TEXT_BYTES-1:0] el_text,
  input wire logic [3:0] el_text_len,
  input wire logic signed [srf_pkg::CONV_W-1:0] el_value,
  input wire logic [3:0] el_frac_digits,
  input wire logic signed [srf_pkg::EXP_W-1:0] el_exp,
  input wire logic el_unit_last,
  input wire logic el_msg_last,
  output logic el_ready,
  // Terminator selection from the command logic
  input wire logic terminator_select_command,
  input wire logic term_sel_crlf,
  output logic term_crlf,
  // Response byte stream towards the link
  output logic [7:0] tx_byte,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic tx_end,
  output logic gpib_eoi_n_out,
  output logic gpib_eoi_oe_n,
  // Program byte stream from the link
  input wire logic [7:0] rx_byte,
  input wire logic rx_valid,
  input wire logic rx_eoi,
  output logic rx_ready,
  output logic [7:0] pm_byte,
  output logic pm_valid,
  output logic pm_end
);
  import srf_pkg::*;

  typedef struct packed {
    srf_fmt_state_t st;
    srf_sep_t sep;
    logic [7:0] tx_byte;
    logic tx_valid;
    logic tx_end;
    logic eoi_n;
    logic eoi_oe_n;
    logic el_ready;
    logic crlf;
    srf_kind_t kind;
    logic [8*TEXT_BYTES-1:0] text;
    logic [3:0] tlen;
    logic [3:0] idx;
    logic [3:0] frac;
    logic unit_last;
    logic msg_last;
    logic neg;
    logic exp_neg;
    logic [EXP_W-1:0] exp_mag;
    logic exp_phase;
    logic conv_start;
    logic [CONV_W-1:0] conv_val;
    logic [3:0] conv_min;
    logic [7:0] pm_byte;
    logic pm_valid;
    logic pm_end;
    logic rx_ready;
    logic word_seen;
    logic sp_pend;
    logic held_valid;
    logic held_end;
    logic [7:0] held_byte;
  } srf_fmt_reg_t;

  srf_fmt_reg_t q;
  srf_fmt_reg_t d;
  logic can_send;
  logic conv_done;
  logic [4*NDIGITS-1:0] conv_bcd;
  logic [3:0] conv_ndig;
  logic [7:0] rx_fold;

  // ==========================================================
  // Helpers
  // ==========================================================
  function automatic logic [7:0] upper_case(input logic [7:0] c);
    if (c >= CH_LOW_A && c <= CH_LOW_Z) begin
      return c & ~CASE_BIT;
    end
    return c;
  endfunction

  function automatic logic [7:0] digit_ascii(input logic [4*NDIGITS-1:0] b, input logic [3:0] i);
    return CH_ZERO + {4'h0, b[i*4 +: 4]};
  endfunction

  srf_dec_digits u_digits (
    .clk(clk),
    .reset(reset),
    .start(q.conv_start),
    .value(q.conv_val),
    .min_digits(q.conv_min),
    .done(conv_done),
    .bcd(conv_bcd),
    .ndig(conv_ndig)
  );

  assign can_send = !q.tx_valid || tx_ready;
  assign rx_fold = upper_case(rx_byte);

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    d = q;
    d.el_ready = 1'b0;
    d.conv_start = 1'b0;
    d.pm_valid = 1'b0;
    d.pm_end = 1'b0;
    if (terminator_select_command) begin
      d.crlf = term_sel_crlf;
    end
    if (can_send) begin
      d.tx_valid = 1'b0;
      d.tx_end = 1'b0;
      d.eoi_n = 1'b1;
      d.eoi_oe_n = 1'b1;
    end

    // ----- Response side -----
    case (q.st)
      FS_IDLE: begin
        if (el_valid && can_send) begin
          if (q.sep != SEP_NONE) begin
            // Bare separator byte, never padded
            d.tx_byte = (q.sep == SEP_SEMI) ? CH_SEMI : CH_COMMA;
            d.tx_valid = 1'b1;
            d.sep = SEP_NONE;
          end else begin
            // No header is ever emitted, so no header space is needed either
            d.el_ready = 1'b1;
            d.kind = el_kind;
            d.text = el_text;
            d.tlen = el_text_len;
            d.unit_last = el_unit_last;
            d.msg_last = el_msg_last;
            d.neg = el_value[CONV_W-1];
            d.exp_neg = el_exp[EXP_W-1];
            d.exp_mag = el_exp[EXP_W-1] ? EXP_W'(-el_exp) : EXP_W'(el_exp);
            d.exp_phase = 1'b0;
            d.idx = '0;
            d.frac = (el_kind == KIND_NR1) ? 4'h0 : (el_frac_digits > FRAC_MAX ? FRAC_MAX : el_frac_digits);
            if (el_kind == KIND_CHAR) begin
              d.st = FS_TEXT;
            end else begin
              // Zero padding gives a leading 0 before the point
              d.conv_start = 1'b1;
              d.conv_val = el_value[CONV_W-1] ? CONV_W'(-el_value) : CONV_W'(el_value);
              d.conv_min = d.frac + MIN_ONE;
              d.st = FS_CONV;
            end
          end
        end
      end
      FS_TEXT: begin
        if (can_send) begin
          d.tx_byte = upper_case(q.text[{q.idx[2:0], 3'h0} +: 8]);
          d.tx_valid = 1'b1;
          if (q.tlen <= MIN_ONE || q.idx == q.tlen - MIN_ONE) begin
            d.st = FS_FIN;
          end else begin
            d.idx = q.idx + MIN_ONE;
          end
        end
      end
      FS_CONV: begin
        if (conv_done) begin
          d.idx = conv_ndig - MIN_ONE;
          // Only a minus is shown on the mantissa, so each value has one spelling
          d.st = q.neg ? FS_SIGN : FS_DIG;
        end
      end
      FS_SIGN: begin
        if (can_send) begin
          d.tx_byte = CH_MINUS;
          d.tx_valid = 1'b1;
          d.st = FS_DIG;
        end
      end
      FS_DIG: begin
        if (can_send) begin
          d.tx_byte = digit_ascii(conv_bcd, q.idx);
          d.tx_valid = 1'b1;
          if (q.idx == 4'h0) begin
            d.st = (q.kind == KIND_NR3 && !q.exp_phase) ? FS_EXPE : FS_FIN;
          end else if (q.frac != 4'h0 && q.idx == q.frac) begin
            d.st = FS_POINT;
          end else begin
            d.idx = q.idx - MIN_ONE;
          end
        end
      end
      FS_POINT: begin
        if (can_send) begin
          d.tx_byte = CH_POINT;
          d.tx_valid = 1'b1;
          d.idx = q.idx - MIN_ONE;
          d.st = FS_DIG;
        end
      end
      FS_EXPE: begin
        if (can_send) begin
          d.tx_byte = CH_EXP;
          d.tx_valid = 1'b1;
          d.frac = 4'h0;
          d.conv_start = 1'b1;
          d.conv_val = CONV_W'(q.exp_mag);
          d.conv_min = MIN_ONE;
          d.st = FS_EXPCONV;
        end
      end
      FS_EXPCONV: begin
        if (conv_done) begin
          d.idx = conv_ndig - MIN_ONE;
          d.st = FS_EXPSIGN;
        end
      end
      FS_EXPSIGN: begin
        if (can_send) begin
          // Sign is written even for a positive exponent
          d.tx_byte = q.exp_neg ? CH_MINUS : CH_PLUS;
          d.tx_valid = 1'b1;
          d.exp_phase = 1'b1;
          d.st = FS_DIG;
        end
      end
      FS_FIN: begin
        if (q.msg_last) begin
          d.st = q.crlf ? FS_CR : FS_LF;
        end else begin
          d.sep = q.unit_last ? SEP_SEMI : SEP_COMMA;
          d.st = FS_IDLE;
        end
      end
      FS_CR: begin
        if (can_send) begin
          d.tx_byte = CH_CR;
          d.tx_valid = 1'b1;
          d.st = FS_LF;
        end
      end
      FS_LF: begin
        if (can_send) begin
          d.tx_byte = CH_LF;
          d.tx_valid = 1'b1;
          d.tx_end = 1'b1;
          d.eoi_n = 1'b0;
          d.eoi_oe_n = 1'b0;
          d.sep = SEP_NONE;
          d.st = FS_IDLE;
        end
      end
      default: begin
        d.st = FS_IDLE;
      end
    endcase

    // ----- Program side -----
    // A collapsed blank costs one stall cycle on the input
    if (q.held_valid) begin
      d.pm_byte = q.held_byte;
      d.pm_valid = 1'b1;
      d.pm_end = q.held_end;
      d.held_valid = 1'b0;
      d.held_end = 1'b0;
      d.rx_ready = 1'b1;
      if (q.held_end) begin
        d.word_seen = 1'b0;
      end
    end else if (rx_valid && q.rx_ready) begin
      if (rx_fold == CH_LF) begin
        // Pending blanks before the terminator are dropped
        d.pm_end = 1'b1;
        d.sp_pend = 1'b0;
        d.word_seen = 1'b0;
      end else if (rx_fold == CH_SPACE || rx_fold == CH_TAB || rx_fold == CH_CR) begin
        if (rx_eoi) begin
          d.pm_end = 1'b1;
          d.sp_pend = 1'b0;
          d.word_seen = 1'b0;
        end else begin
          d.sp_pend = q.word_seen;
        end
      end else if (rx_fold == CH_SEMI || rx_fold == CH_COMMA || rx_fold == CH_COLON) begin
        d.pm_byte = rx_fold;
        d.pm_valid = 1'b1;
        d.pm_end = rx_eoi;
        d.sp_pend = 1'b0;
        d.word_seen = 1'b0;
      end else if (q.sp_pend) begin
        // A run of blanks between two words becomes one space
        d.pm_byte = CH_SPACE;
        d.pm_valid = 1'b1;
        d.held_byte = rx_fold;
        d.held_valid = 1'b1;
        d.held_end = rx_eoi;
        d.rx_ready = 1'b0;
        d.sp_pend = 1'b0;
        d.word_seen = 1'b1;
      end else begin
        d.pm_byte = rx_fold;
        d.pm_valid = 1'b1;
        d.pm_end = rx_eoi;
        d.word_seen = !rx_eoi;
      end
    end
  end

  // ==========================================================
  // State register
  // ==========================================================
  always_ff @(posedge clk) begin
    if (reset) begin
      q <= '0;
      q.st <= FS_IDLE;
      q.sep <= SEP_NONE;
      q.kind <= KIND_CHAR;
      q.eoi_n <= 1'b1;
      q.eoi_oe_n <= 1'b1;
      q.rx_ready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign el_ready = q.el_ready;
  assign term_crlf = q.crlf;
  assign tx_byte = q.tx_byte;
  assign tx_valid = q.tx_valid;
  assign tx_end = q.tx_end;
  assign gpib_eoi_n_out = q.eoi_n;
  assign gpib_eoi_oe_n = q.eoi_oe_n;
  assign rx_ready = q.rx_ready;
  assign pm_byte = q.pm_byte;
  assign pm_valid = q.pm_valid;
  assign pm_end = q.pm_end;

endmodule

// ===== tb/srf_checker.sv
module srf_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic terminator_select_command,
  input wire logic term_sel_crlf,
  input wire logic term_crlf,
  input wire logic [7:0] tx_byte,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic tx_end,
  input wire logic gpib_eoi_n_out,
  input wire logic gpib_eoi_oe_n,
  input wire logic [7:0] rx_byte,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic [7:0] pm_byte,
  input wire logic pm_valid,
  input wire logic pm_end
);
  timeunit 1ns;
  timeprecision 1ps;
  import srf_pkg::*;
  // ======================================
  // Response and program streams
  // ======================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  eoi_end_a: assert property (tx_valid && tx_end |-> !gpib_eoi_n_out && !gpib_eoi_oe_n && tx_byte == CH_LF)
    else $error("final byte lacks end mark or newline");
  eoi_free_a: assert property (!(tx_valid && tx_end) |-> gpib_eoi_oe_n && gpib_eoi_n_out)
    else $error("end line driven off the final byte");
  hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte) && $stable(tx_end))
    else $error("response byte changed while stalled");
  upper_only_a: assert property (tx_valid |-> !(tx_byte inside {[CH_LOW_A:CH_LOW_Z]}))
    else $error("lower case byte sent");
  no_blank_a: assert property (tx_valid |-> tx_byte != CH_SPACE && tx_byte != CH_TAB)
    else $error("blank sent in headerless response");
  cr_lf_a: assert property (tx_valid && tx_ready && tx_byte == CH_CR |-> term_crlf ##[1:8] (tx_valid && tx_end))
    else $error("carriage return not followed by newline");
  term_load_a: assert property (terminator_select_command |=> term_crlf == $past(term_sel_crlf))
    else $error("terminator selection not loaded");
  term_hold_a: assert property (!reset && !terminator_select_command |=> $stable(term_crlf))
    else $error("terminator selection changed unasked");
  lf_end_a: assert property (rx_valid && rx_ready && rx_byte == CH_LF |=> pm_end && !pm_valid)
    else $error("newline did not end program message");
  collapse_a: assert property (!rx_ready |-> pm_valid && pm_byte == CH_SPACE ##1 rx_ready && pm_valid)
    else $error("blank run not collapsed to one space");
  crlf_c: cover property (tx_valid && tx_ready && tx_byte == CH_CR);
  eoi_c: cover property (tx_ready && !gpib_eoi_oe_n);
  collapse_c: cover property (!rx_ready);
endmodule

bind srf_formatter srf_checker srf_checker_i (.clk(clk), .reset(reset),
  .terminator_select_command(terminator_select_command), .term_sel_crlf(term_sel_crlf), .term_crlf(term_crlf),
  .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_end(tx_end), .gpib_eoi_n_out(gpib_eoi_n_out),
  .gpib_eoi_oe_n(gpib_eoi_oe_n), .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_ready(rx_ready),
  .pm_byte(pm_byte), .pm_valid(pm_valid), .pm_end(pm_end));

// ===== tb/srf_host_model.sv
module srf_host_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic stall,
  input wire logic [7:0] tx_byte,
  input wire logic tx_valid,
  input wire logic tx_end,
  output logic tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got [$];
  int n_msg = 0;
  logic [1:0] phase_q = 2'h0;
  // ======================================
  // Reader
  // ======================================
  // Stalling reader is ready one clock in four to stretch every hold
  always @(posedge clk) begin
    if (reset) begin
      phase_q <= 2'h0;
      tx_ready <= 1'b1;
    end else begin
      phase_q <= phase_q + 2'h1;
      tx_ready <= !stall || phase_q == 2'h2;
      if (tx_valid && tx_ready) begin
        got.push_back(tx_byte);
        if (tx_end) begin
          n_msg <= n_msg + 1;
        end
      end
    end
  end
endmodule

// ===== tb/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import srf_pkg::*;
  typedef struct {
    srf_kind_t k;
    logic [63:0] txt;
    logic [3:0] len;
    logic signed [31:0] v;
    logic [3:0] fr;
    logic signed [7:0] e;
    logic ul;
    logic ml;
    logic [1:0] sel;
    string x;
  } srf_row_t;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic el_valid = 1'b0;
  srf_kind_t el_kind = KIND_CHAR;
  logic [63:0] el_text = 64'h0;
  logic [3:0] el_text_len = 4'h1;
  logic signed [31:0] el_value = 32'h0;
  logic [3:0] el_frac_digits = 4'h0;
  logic signed [7:0] el_exp = 8'h0;
  logic el_unit_last = 1'b0;
  logic el_msg_last = 1'b0;
  logic terminator_select_command = 1'b0;
  logic term_sel_crlf = 1'b0;
  logic [7:0] rx_byte = 8'h0;
  logic rx_valid = 1'b0;
  logic rx_eoi = 1'b0;
  logic stall = 1'b0;
  logic el_ready, term_crlf, tx_valid, tx_ready, tx_end, gpib_eoi_n_out, gpib_eoi_oe_n;
  logic rx_ready, pm_valid, pm_end;
  logic [7:0] tx_byte, pm_byte;
  int fail_count = 0;
  int num_checks = 0;
  int n_end = 0;
  int sent = 0;
  int n;
  string exp_s;
  logic [7:0] pm_q [$];
  srf_row_t rows [6];

  always #5 clk = ~clk;

  srf_formatter srf_formatter_i (.clk(clk), .reset(reset), .el_valid(el_valid), .el_kind(el_kind),
    .el_text(el_text), .el_text_len(el_text_len), .el_value(el_value), .el_frac_digits(el_frac_digits),
    .el_exp(el_exp), .el_unit_last(el_unit_last), .el_msg_last(el_msg_last), .el_ready(el_ready),
    .terminator_select_command(terminator_select_command), .term_sel_crlf(term_sel_crlf),
    .term_crlf(term_crlf), .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_end(tx_end),
    .gpib_eoi_n_out(gpib_eoi_n_out), .gpib_eoi_oe_n(gpib_eoi_oe_n), .rx_byte(rx_byte), .rx_valid(rx_valid),
    .rx_eoi(rx_eoi), .rx_ready(rx_ready), .pm_byte(pm_byte), .pm_valid(pm_valid), .pm_end(pm_end));
  srf_host_model host_i (.clk(clk), .reset(reset), .stall(stall), .tx_byte(tx_byte), .tx_valid(tx_valid),
    .tx_end(tx_end), .tx_ready(tx_ready));

  always @(posedge clk) begin
    if (pm_valid === 1'b1) begin
      pm_q.push_back(pm_byte);
    end
    if (pm_end === 1'b1) begin
      n_end++;
    end
  end

  // ======================================
  // Tasks
  // ======================================
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Selection waits for the stream to drain so it lands on the next message
  task automatic send_el(input srf_row_t r);
    @(posedge clk);
    if (r.sel[1]) begin
      for (n = 0; host_i.n_msg != sent && n < 2000; n++) @(posedge clk);
      term_sel_crlf <= r.sel[0];
      terminator_select_command <= 1'b1;
      @(posedge clk);
      terminator_select_command <= 1'b0;
    end
    el_kind <= r.k;
    el_text <= r.txt;
    el_text_len <= r.len;
    el_value <= r.v;
    el_frac_digits <= r.fr;
    el_exp <= r.e;
    el_unit_last <= r.ul;
    el_msg_last <= r.ml;
    el_valid <= 1'b1;
    for (n = 0; n < 400; n++) begin
      @(posedge clk);
      if (el_ready === 1'b1) break;
    end
    el_valid <= 1'b0;
    sent += r.ml;
  endtask

  task automatic rx_send(input logic [7:0] b, input logic eoi);
    rx_byte <= b;
    rx_eoi <= eoi;
    rx_valid <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (rx_ready === 1'b1) break;
    end
  endtask

  // ======================================
  // Sequence
  // ======================================
  initial begin
    rows[0] = '{KIND_CHAR, 64'h6261, 4'h2, 32'sh0, 4'h0, 8'sh0, 1'b0, 1'b0, 2'h0, "AB,"};
    rows[1] = '{KIND_NR1, 64'h0, 4'h1, -32'sh4D2, 4'h0, 8'sh0, 1'b1, 1'b0, 2'h0, "-1234;"};
    rows[2] = '{KIND_NR2, 64'h0, 4'h1, 32'sh5, 4'h2, 8'sh0, 1'b0, 1'b0, 2'h0, "0.05,"};
    rows[3] = '{KIND_NR3, 64'h0, 4'h1, 32'sh7B, 4'h2, 8'sh2D, 1'b1, 1'b1, 2'h0, "1.23E+45\n"};
    rows[4] = '{KIND_NR3, 64'h0, 4'h1, -32'sh7B, 4'h1, -8'sh7, 1'b1, 1'b1, 2'h3, "-12.3E-7\r\n"};
    rows[5] = '{KIND_NR1, 64'h0, 4'h1, 32'sh0, 4'h0, 8'sh0, 1'b1, 1'b1, 2'h2, "0\n"};
    repeat (5) @(posedge clk);
    #1;
    chk("tx_valid in reset", 8'h0, {7'h0, tx_valid});
    chk("eoi enable in reset", 8'h1, {7'h0, gpib_eoi_oe_n});
    @(posedge clk);
    reset <= 1'b0;
    $display("test reset done");
    exp_s = "";
    foreach (rows[i]) begin
      stall <= (i % 2 == 1);
      send_el(rows[i]);
      exp_s = {exp_s, rows[i].x};
    end
    for (n = 0; host_i.n_msg != 3 && n < 3000; n++) @(posedge clk);
    chk("response length", 8'(exp_s.len()), 8'(host_i.got.size()));
    foreach (exp_s[i]) chk("response byte", exp_s[i], host_i.got[i]);
    $display("test responses done");
    exp_s = "  sYs  a ,b\t;c \r\n";
    foreach (exp_s[i]) rx_send(exp_s[i], 1'b0);
    rx_send(8'h71, 1'b1);
    rx_valid <= 1'b0;
    repeat (3) @(posedge clk);
    exp_s = "SYS A,B;CQ";
    chk("program length", 8'(exp_s.len()), 8'(pm_q.size()));
    foreach (exp_s[i]) chk("program byte", exp_s[i], pm_q[i]);
    chk("program ends", 8'h2, 8'(n_end));
    $display("test program done");
    term_sel_crlf <= 1'b1;
    terminator_select_command <= 1'b1;
    @(posedge clk);
    terminator_select_command <= 1'b0;
    reset <= 1'b1;
    #1;
    chk("selection set", 8'h1, {7'h0, term_crlf});
    @(posedge clk);
    reset <= 1'b0;
    #1;
    chk("selection after reset", 8'h0, {7'h0, term_crlf});
    chk("rx_ready after reset", 8'h1, {7'h0, rx_ready});
    $display("test midrun reset done");
    test_done();
  end

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    $display("BAD watchdog expected finish seen timeout");
    test_done();
  end
endmodule
